// ==== hw/pfh_consts.svh ====
/*
 Timing counts, command addresses and command bytes for the flash host controller.
 Assumes a 100 MHz clock and a byte-wide asynchronous flash on the far side of the pins.
*/
// Behaviour
// - Host strobes writes with output enable high
// - Chip erase is six fixed byte writes
// - Host issues sector erase as six writes
// - Host waits for operation end before access
// - Unlock cycles use 555/AAA addresses with AA/55 bytes
`ifndef PFH_CONSTS_SVH
`define PFH_CONSTS_SVH

`define PFH_CLK_PERIOD_NS 10
`define PFH_T_SETUP_NS 20
`define PFH_T_WP_NS 50
`define PFH_T_WPH_NS 30
`define PFH_T_ACC_NS 100
`define PFH_CYC(ns) (((ns) + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_SETUP_CYC `PFH_CYC(`PFH_T_SETUP_NS)
`define PFH_WP_CYC `PFH_CYC(`PFH_T_WP_NS)
`define PFH_WPH_CYC `PFH_CYC(`PFH_T_WPH_NS)
`define PFH_ACC_CYC `PFH_CYC(`PFH_T_ACC_NS)
`define PFH_SYNC_CYC 4
`define PFH_ERASE_WAIT_DEF 32'd600000000

`define PFH_CMD_ADDR_A 12'h555
`define PFH_CMD_ADDR_B 12'haaa
`define PFH_UNLOCK_1 8'haa
`define PFH_UNLOCK_2 8'h55
`define PFH_ERASE_SETUP 8'h80
`define PFH_CHIP_ERASE 8'h10
`define PFH_SECTOR_ERASE 8'h30
`define PFH_BOOT_LOCK 8'h40
`define PFH_LAST_CYCLE 3'd5

`endif

// ==== hw/pfh_pkg.sv ====
/*
 Types of the flash host controller: operations, states and the pin bundle.
 Assumes pfh_consts.svh for all figures.
*/
package pfh_pkg;

   typedef enum logic [1:0] {
      PFH_OP_READ,
      PFH_OP_CHIP_ERASE,
      PFH_OP_SECTOR_ERASE,
      PFH_OP_BOOT_LOCK
   } pfh_op_t;

   typedef enum logic [2:0] {
      PFH_IDLE,
      PFH_SETUP,
      PFH_STROBE,
      PFH_RECOVER,
      PFH_READ_ACC,
      PFH_ERASE_WAIT
   } pfh_state_t;

   typedef struct packed {
      logic [18:0] address_lines;
      logic chip_sel_n;
      logic out_en_n;
      logic write_n;
      logic [7:0] data_out;
      logic data_oe;
   } pfh_pins_t;

   typedef struct packed {
      logic [18:0] address;
      logic [7:0] data;
   } pfh_bus_word_t;

endpackage

// ==== hw/pfh_sync3.sv ====
/*
 Three-stage synchroniser for the flash data lines.
 Assumes the lines are asynchronous to clock; a bit changes once stages two and three agree.
*/
`timescale 1ns/1ns
module pfh_sync3
   import pfh_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] async_in,
   output logic [7:0] sync_out
);
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] s3_q;
   logic [7:0] out_d;
   logic [7:0] out_q;

   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_bit
         always_comb
         begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
         end
      end
   endgenerate

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
         out_q <= 8'h00;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;
endmodule // pfh_sync3

// ==== hw/pfh_host.sv ====
/*
 Host controller for a byte-wide asynchronous flash: reads, chip erase, sector erase, boot lock.
 Assumes one command at a time on the user port and that the flash is the only load on the pins.
*/
`timescale 1ns/1ns
`include "pfh_consts.svh"
module pfh_host
   import pfh_pkg::*;
#(
   parameter logic [31:0] ERASE_WAIT_CYC = `PFH_ERASE_WAIT_DEF
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire pfh_op_t cmd_op,
   input wire logic [18:0] cmd_addr,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic busy,
   input wire logic [7:0] data_lines_in,
   output pfh_pins_t pins
);
   pfh_state_t state_q, state_d;
   pfh_op_t op_q, op_d;
   logic [18:0] sa_q, sa_d;
   logic [2:0] idx_q, idx_d;
   logic [31:0] cnt_q, cnt_d;
   pfh_pins_t pins_q, pins_d;
   logic ready_q, ready_d;
   logic rv_q, rv_d;
   logic [7:0] rdata_q, rdata_d;
   logic busy_q, busy_d;
   logic [7:0] data_sync;
   pfh_bus_word_t word;

   pfh_sync3 u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(data_lines_in),
      .sync_out(data_sync)
   );

   function automatic pfh_bus_word_t cmd_word(input logic [2:0] idx, input pfh_op_t op, input logic [18:0] sa);
      pfh_bus_word_t w;
      w.address = {7'h00, `PFH_CMD_ADDR_A};
      w.data = `PFH_UNLOCK_1;
      unique case (idx)
         3'd0, 3'd3: w.data = `PFH_UNLOCK_1;
         3'd1, 3'd4:
         begin
            w.address = {7'h00, `PFH_CMD_ADDR_B};
            w.data = `PFH_UNLOCK_2;
         end
         3'd2: w.data = `PFH_ERASE_SETUP;
         default:
         begin
            if (op == PFH_OP_SECTOR_ERASE)
            begin
               w.address = sa;
               w.data = `PFH_SECTOR_ERASE;
            end
            else if (op == PFH_OP_BOOT_LOCK)
               w.data = `PFH_BOOT_LOCK;
            else
               w.data = `PFH_CHIP_ERASE;
         end
      endcase
      return w;
   endfunction

   always_comb
   begin
      state_d = state_q;
      op_d = op_q;
      sa_d = sa_q;
      idx_d = idx_q;
      cnt_d = cnt_q;
      pins_d = pins_q;
      ready_d = ready_q;
      rv_d = 1'b0;
      rdata_d = rdata_q;
      busy_d = busy_q;
      word = cmd_word(idx_q, op_q, sa_q);
      unique case (state_q)
         PFH_IDLE:
         begin
            if (cmd_valid && ready_q)
            begin
               op_d = cmd_op;
               sa_d = cmd_addr;
               idx_d = 3'd0;
               cnt_d = 32'd0;
               ready_d = 1'b0;
               busy_d = 1'b1;
               if (cmd_op == PFH_OP_READ)
               begin
                  pins_d.address_lines = cmd_addr;
                  pins_d.chip_sel_n = 1'b0;
                  pins_d.out_en_n = 1'b0;
                  state_d = PFH_READ_ACC;
               end
               else
               begin
                  word = cmd_word(3'd0, cmd_op, cmd_addr);
                  pins_d.address_lines = word.address;
                  pins_d.data_out = word.data;
                  pins_d.data_oe = 1'b1;
                  pins_d.chip_sel_n = 1'b0;
                  state_d = PFH_SETUP;
               end
            end
         end
         PFH_SETUP:
         begin
            cnt_d = cnt_q + 32'd1;
            if (cnt_q == 32'(`PFH_SETUP_CYC - 1))
            begin
               cnt_d = 32'd0;
               pins_d.write_n = 1'b0;
               state_d = PFH_STROBE;
            end
         end
         PFH_STROBE:
         begin
            cnt_d = cnt_q + 32'd1;
            if (cnt_q == 32'(`PFH_WP_CYC - 1))
            begin
               cnt_d = 32'd0;
               pins_d.write_n = 1'b1;
               state_d = PFH_RECOVER;
            end
         end
         PFH_RECOVER:
         begin
            cnt_d = cnt_q + 32'd1;
            pins_d.chip_sel_n = 1'b1;
            if (cnt_q == 32'(`PFH_WPH_CYC - 1))
            begin
               cnt_d = 32'd0;
               if (idx_q == `PFH_LAST_CYCLE)
               begin
                  pins_d.data_oe = 1'b0;
                  state_d = PFH_ERASE_WAIT;
               end
               else
               begin
                  idx_d = idx_q + 3'd1;
                  word = cmd_word(idx_q + 3'd1, op_q, sa_q);
                  pins_d.address_lines = word.address;
                  pins_d.data_out = word.data;
                  pins_d.chip_sel_n = 1'b0;
                  state_d = PFH_SETUP;
               end
            end
         end
         PFH_READ_ACC:
         begin
            cnt_d = cnt_q + 32'd1;
            // Synchroniser delay added so the sampled byte is settled
            if (cnt_q == 32'(`PFH_ACC_CYC + `PFH_SYNC_CYC - 1))
            begin
               pins_d.chip_sel_n = 1'b1;
               pins_d.out_en_n = 1'b1;
               rdata_d = data_sync;
               rv_d = 1'b1;
               ready_d = 1'b1;
               busy_d = 1'b0;
               state_d = PFH_IDLE;
            end
         end
         PFH_ERASE_WAIT:
         begin
            // hold off until done
            // Fixed worst-case wait; no status polling, so it always costs the full time
            cnt_d = cnt_q + 32'd1;
            if (cnt_q >= ERASE_WAIT_CYC - 32'd1)
            begin
               rdata_d = 8'h00;
               rv_d = 1'b1;
               ready_d = 1'b1;
               busy_d = 1'b0;
               state_d = PFH_IDLE;
            end
         end
      endcase
      // Ready follows idle so a back-to-back request is taken at once
      ready_d = (state_d == PFH_IDLE);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_q <= PFH_IDLE;
         op_q <= PFH_OP_READ;
         sa_q <= 19'h00000;
         idx_q <= 3'd0;
         cnt_q <= 32'd0;
         pins_q <= '{address_lines: 19'h00000, chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
                     data_out: 8'h00, data_oe: 1'b0};
         ready_q <= 1'b0;
         rv_q <= 1'b0;
         rdata_q <= 8'h00;
         busy_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         op_q <= op_d;
         sa_q <= sa_d;
         idx_q <= idx_d;
         cnt_q <= cnt_d;
         pins_q <= pins_d;
         ready_q <= ready_d;
         rv_q <= rv_d;
         rdata_q <= rdata_d;
         busy_q <= busy_d;
      end
   end

   assign pins = pins_q;
   assign cmd_ready = ready_q;
   assign rsp_valid = rv_q;
   assign rsp_data = rdata_q;
   assign busy = busy_q;

   logic [2:0] rises_q;
   always_ff @(posedge clock)
   begin
      if (!rst_n || state_q == PFH_IDLE)
         rises_q <= 3'd0;
      else if ($rose(pins_q.write_n))
         rises_q <= rises_q + 3'd1;
   end

   property p_strobe_levels;
      @(posedge clock) disable iff (!rst_n) !pins_q.write_n |-> !pins_q.chip_sel_n && pins_q.out_en_n;
   endproperty
   a_strobe_levels: assert property (p_strobe_levels) else $error("write strobe low without select");

   property p_no_contention;
      @(posedge clock) disable iff (!rst_n) pins_q.data_oe |-> pins_q.out_en_n;
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("data driven while reading");

   property p_pulse_width;
      @(posedge clock) disable iff (!rst_n) $fell(pins_q.write_n) |-> !pins_q.write_n [*5] ##1 pins_q.write_n;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("write pulse width wrong");

   property p_six_writes;
      @(posedge clock) disable iff (!rst_n) $rose(state_q == PFH_ERASE_WAIT) |-> rises_q == 3'd6;
   endproperty
   a_six_writes: assert property (p_six_writes) else $error("erase sequence not six writes");

   property p_sector_last;
      @(posedge clock) disable iff (!rst_n)
         $rose(pins_q.write_n) && idx_q == 3'd5 && op_q == PFH_OP_SECTOR_ERASE
         |-> pins_q.data_out == 8'h30 && pins_q.address_lines == sa_q;
   endproperty
   a_sector_last: assert property (p_sector_last) else $error("bad sixth sector cycle");

   property p_unlock_addr;
      @(posedge clock) disable iff (!rst_n)
         $fell(pins_q.write_n) && idx_q != 3'd5
         |-> pins_q.address_lines[11:0] == 12'h555 || pins_q.address_lines[11:0] == 12'haaa;
   endproperty
   a_unlock_addr: assert property (p_unlock_addr) else $error("bad command address");

   property p_wait_quiet;
      @(posedge clock) disable iff (!rst_n) state_q == PFH_ERASE_WAIT |-> pins_q.chip_sel_n && busy_q;
   endproperty
   a_wait_quiet: assert property (p_wait_quiet) else $error("access during erase");

   c_read: cover property (@(posedge clock) disable iff (!rst_n) rv_q && op_q == PFH_OP_READ);
   c_chip: cover property (@(posedge clock) disable iff (!rst_n) rv_q && op_q == PFH_OP_CHIP_ERASE);
   c_sector: cover property (@(posedge clock) disable iff (!rst_n) rv_q && op_q == PFH_OP_SECTOR_ERASE);
   c_lock: cover property (@(posedge clock) disable iff (!rst_n) rv_q && op_q == PFH_OP_BOOT_LOCK);
endmodule // pfh_host

// ==== verif/pfh_flash_model.sv ====
/*
 Behavioural byte-wide flash: reads, six-cycle command decoder, block erase, boot lockout.
 Assumes the bench resolves the data wire; a pulse on fresh fits a new unerased part.
*/
`timescale 1ns/1ns
module pfh_flash_model
   import pfh_pkg::*;
#(
   parameter int ERASE_NS = 150
)
(
   input wire pfh_pins_t pins,
   input wire logic [7:0] dq_in,
   input wire logic fresh,
   output logic [7:0] dq_out,
   output logic dq_en,
   output int viol
);
   logic [10:0] ers = '0;
   logic locked = 1'b0;
   logic busy = 1'b0;
   logic wr = 1'b0;
   logic [18:0] alat = '0;
   int idx = 0;
   function automatic int blk(logic [18:0] a);
      return a < 19'h04000 ? 0 : a < 19'h06000 ? 1 : a < 19'h08000 ? 2 : a < 19'h10000 ? 3 : 3 + a[18:16];
   endfunction
   assign dq_en = !pins.chip_sel_n && !pins.out_en_n && pins.write_n;
   assign dq_out = (ers[blk(pins.address_lines)] ? 8'hff :
      pins.address_lines[7:0] ^ pins.address_lines[15:8] ^ {pins.address_lines[18:16], 5'h00}) ^ {8{busy}};
   initial viol = 0;
   always @(posedge fresh)
   begin
      ers = '0;
      locked = 1'b0;
      idx = 0;
   end
   always @(negedge pins.write_n or negedge pins.chip_sel_n)
      if (!pins.write_n && !pins.chip_sel_n)
      begin
         alat = pins.address_lines;
         wr = pins.out_en_n;
         if (!pins.out_en_n)
            viol++;
      end
   always @(posedge pins.write_n or posedge pins.chip_sel_n)
      if (wr)
      begin
         wr = 1'b0;
         step(alat, dq_in);
      end
   task automatic step(logic [18:0] a, logic [7:0] d);
      logic [11:0] ea [5] = '{12'h555, 12'haaa, 12'h555, 12'h555, 12'haaa};
      logic [7:0] ed [5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
      if (busy)
         return;
      if (idx < 5)
      begin
         idx = (a[11:0] == ea[idx] && d == ed[idx]) ? idx + 1 : 0;
         return;
      end
      idx = 0;
      if (!(d inside {8'h10, 8'h30, 8'h40}))
         return;
      busy = 1'b1;
      #(ERASE_NS);
      if (d == 8'h10 && a[11:0] == 12'h555)
         ers = locked ? 11'h7fe : 11'h7ff;
      if (d == 8'h30 && !(locked && blk(a) == 0))
         ers[blk(a)] = 1'b1;
      if (d == 8'h40 && a[11:0] == 12'h555)
         locked = 1'b1;
      busy = 1'b0;
   endtask
endmodule // pfh_flash_model

// ==== verif/parallel_flash_command_erase_test.sv ====
/*
 Self-checking bench of the flash host against the behavioural flash.
 Assumes a short erase wait; expectations come from a block map kept here.
*/
`timescale 1ns/1ns
module parallel_flash_command_erase_test
   import pfh_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic fresh = 1'b0;
   pfh_op_t cmd_op = PFH_OP_READ;
   logic [18:0] cmd_addr = '0;
   logic cmd_ready, rsp_valid, busy, f_en;
   logic [7:0] rsp_data, f_dq, wire_dq;
   logic [7:0] cyc = '0;
   pfh_pins_t pins;
   int viol, b;
   int mismatches = 0;
   int n_compared = 0;
   logic [10:0] ers = '0;
   initial forever #5 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 8'h01;
   // Released wire never holds its last value
   assign wire_dq = pins.data_oe ? pins.data_out : f_en ? f_dq : cyc;
   pfh_host #(.ERASE_WAIT_CYC(32'd20)) pfh_host_i (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .busy(busy), .data_lines_in(wire_dq), .pins(pins));
   pfh_flash_model pfh_flash_model_i (.pins(pins), .dq_in(wire_dq), .fresh(fresh), .dq_out(f_dq),
      .dq_en(f_en), .viol(viol));
   function automatic int blk(logic [18:0] a);
      return a < 19'h04000 ? 0 : a < 19'h06000 ? 1 : a < 19'h08000 ? 2 : a < 19'h10000 ? 3 : 3 + a[18:16];
   endfunction
   function automatic int base(int k);
      return k == 0 ? 0 : k == 1 ? 32'h4000 : k == 2 ? 32'h6000 : k == 3 ? 32'h8000 : (k - 3) << 16;
   endfunction
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(logic [7:0] got, logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic issue(pfh_op_t op, logic [18:0] a, output logic [7:0] d);
      int n;
      @(posedge clock);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_valid <= 1'b1;
      n = 0;
      do @(posedge clock); while (cmd_ready !== 1'b1 && ++n < 50);
      cmd_valid <= 1'b0;
      @(posedge clock);
      check({7'h00, busy}, 8'h01);
      do @(posedge clock); while (rsp_valid !== 1'b1 && ++n < 400);
      if (n >= 400)
      begin
         check(8'h01, 8'h00);
         tally_and_finish();
      end
      check({7'h00, busy}, 8'h00);
      d = rsp_data;
   endtask
   task automatic rd(logic [18:0] a);
      logic [7:0] d;
      issue(PFH_OP_READ, a, d);
      check(d, ers[blk(a)] ? 8'hff : a[7:0] ^ a[15:8] ^ {a[18:16], 5'h00});
   endtask
   task automatic er(pfh_op_t op, logic [18:0] a);
      logic [7:0] d;
      issue(op, a, d);
      check(d, 8'h00);
   endtask
   task automatic sweep();
      for (int k = 0; k < 11; k++)
      begin
         rd(19'(base(k)));
         rd(19'(base(k + 1) - 1));
         rd(19'(base(k) + $urandom_range(base(k + 1) - base(k) - 1)));
      end
   endtask
   always @(posedge clock)
      if (pins.data_oe === 1'b1 && f_en === 1'b1)
         check(8'h01, 8'h00);
   initial
   begin
      void'($urandom(57));
      repeat (5) @(posedge clock);
      check({4'h0, pins.chip_sel_n, pins.out_en_n, pins.write_n, pins.data_oe}, 8'h0e);
      check({5'h00, cmd_ready, rsp_valid, busy}, 8'h00);
      rst_n <= 1'b1;
      repeat (20) rd(19'($urandom));
      sweep();
      er(PFH_OP_SECTOR_ERASE, 19'h04000 + 19'($urandom_range(8191)));
      ers[1] = 1'b1;
      b = 4 + $urandom_range(6);
      er(PFH_OP_SECTOR_ERASE, 19'(base(b) + $urandom_range(65535)));
      ers[b] = 1'b1;
      sweep();
      er(PFH_OP_CHIP_ERASE, 19'h7ffff);
      ers = 11'h7ff;
      sweep();
      fresh <= 1'b1;
      @(posedge clock) fresh <= 1'b0;
      ers = '0;
      er(PFH_OP_BOOT_LOCK, '0);
      er(PFH_OP_SECTOR_ERASE, 19'($urandom_range(16383)));
      sweep();
      er(PFH_OP_CHIP_ERASE, '0);
      ers = 11'h7fe;
      sweep();
      check(8'(viol), 8'h00);
      tally_and_finish();
   end
endmodule // parallel_flash_command_erase_test
